/* pmc_pkg.sv */
// Purpose: shared constants, types and decoding for the power mode block
// Assumes: one clock, fast oscillator modelled as the bus clock
// Notes: offsets are byte addresses on a 4-bit register window
package pmc_pkg;
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] MODE_OFFSET = 4'h0;
  localparam logic [AXI_AW-1:0] CTRL_OFFSET = 4'h4;
  localparam int DIV_LSB = 5;
  localparam int SLOW_RDY_BIT = 3;
  localparam int FAST_RDY_BIT = 2;
  localparam int IDLE_SEL_BIT = 1;
  localparam int HIGH_SEL_BIT = 0;
  localparam int KEEP_BIT = 7;
  localparam int LOW_VOLTAGE_RESET_FLAG_BIT = 2;
  localparam int LRF_BIT = 1;
  localparam int WRF_BIT = 0;
  localparam logic [2:0] DIV_RST = 3'h6;
  localparam logic IDLE_SEL_RST = 1'b1;
  localparam logic HIGH_SEL_RST = 1'b0;
  localparam logic KEEP_RST = 1'b0;
  localparam int unsigned FAST_READY_CYC = 16;
  localparam int unsigned SLOW_READY_TICKS = 2;
  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {PM_RUN, PM_DEEP, PM_LIGHT, PM_SLOW_IDLE_MODE, PM_CLOCKED_IDLE_MODE}
    pmc_state_t;

  // 0 = undivided fast, 1..6 = fast / 2**n, 7 = slow clock
  function automatic logic [2:0] pmc_div_code(input logic hl,
                                              input logic [2:0] cks);
    if (hl)
      return 3'h0;
    else if (cks < 3'h2)
      return SEL_SLOW;
    else
      return 3'(4'h8 - {1'b0, cks});
  endfunction : pmc_div_code
endpackage : pmc_pkg

/* pmc_clk_if.sv */
// Purpose: carries clock selection and ticks between controller and divider
// Assumes: both ends on aclk
// Notes: none
`timescale 1ns/1ps
interface pmc_clk_if;
  logic [2:0] want_code;
  logic [2:0] cur_code;
  logic sys_run;
  logic fast_run;
  logic slow_tick;
  logic sys_tick;
  logic div16_tick;
  logic div64_tick;
  modport ctl (output want_code, sys_run, fast_run, slow_tick,
               input cur_code, sys_tick, div16_tick, div64_tick);
  modport div (input want_code, sys_run, fast_run, slow_tick,
               output cur_code, sys_tick, div16_tick, div64_tick);
endinterface : pmc_clk_if

/* pmc_ready_timer.sv */
// Purpose: oscillator ready flag after a number of source ticks
// Assumes: tick is a one-cycle pulse on aclk, or tied high to count aclk cycles
// Notes: flag drops at once when the source stops
`timescale 1ns/1ps
module pmc_ready_timer #(
  parameter int unsigned N = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // source state
  input wire logic run,
  input wire logic tick,
  // result
  output logic ready
);
  logic [4:0] cnt_reg;
  wire last_tick = tick && (cnt_reg == 5'(N - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_reg <= 5'h0;
      ready <= 1'b0;
    end
    else if (tick && !ready)
    begin
      cnt_reg <= cnt_reg + 5'h1;
      ready <= last_tick;
    end
  end
endmodule : pmc_ready_timer

/* pmc_clk_div.sv */
// Purpose: fast clock prescaler and glitch-free system tick selector
// Assumes: slow_tick already synchronised
// Notes: selection changes only at the end of the running period
`timescale 1ns/1ps
module pmc_clk_div (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // selection and ticks
  pmc_clk_if.div clk_if
);
  import pmc_pkg::*;
  logic [5:0] cnt_reg;
  logic [2:0] cur_reg;
  logic sys_tick_reg;
  logic d16_reg;
  logic d64_reg;
  wire cur_slow = (cur_reg == SEL_SLOW);
  wire [5:0] mask = 6'((7'h1 << cur_reg) - 7'h1);
  wire fast_end = clk_if.fast_run && ((cnt_reg | ~mask) == 6'h3f);
  wire period_end = cur_slow ? clk_if.slow_tick : fast_end;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 6'h0;
      cur_reg <= SEL_SLOW;
      sys_tick_reg <= 1'b0;
      d16_reg <= 1'b0;
      d64_reg <= 1'b0;
    end
    else
    begin
      if (clk_if.fast_run)
        cnt_reg <= cnt_reg + 6'h1;
      if (period_end)
        cur_reg <= clk_if.want_code; // RULE18
      sys_tick_reg <= clk_if.sys_run && period_end;
      d16_reg <= clk_if.fast_run && (cnt_reg[3:0] == 4'hf); // RULE11
      d64_reg <= clk_if.fast_run && (cnt_reg == 6'h3f); // RULE11
    end
  end

  assign clk_if.cur_code = cur_reg;
  assign clk_if.sys_tick = sys_tick_reg;
  assign clk_if.div16_tick = d16_reg;
  assign clk_if.div64_tick = d64_reg;

  AST_SWITCH_AT_END: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur_reg != $past(cur_reg)) |-> $past(period_end)) // RULE18
    else $error("clock source switched mid period");
endmodule : pmc_clk_div

/* pmc_power_ctrl.sv */
// Purpose: operating mode and system clock controller with AXI4-Lite regs
// Assumes: halt_exec and wake_req are one-cycle pulses on aclk
// Notes: slow_osc_pin is asynchronous and is synchronised here
//
// Functional notes
// RULE1: deepest sleep only possible when watchdog is register controlled.
// RULE2: halt, idle off, watchdog and detector off: stop all, hold watchdog.
// RULE3: never enter deepest sleep while low voltage detect is enabled.
// RULE4: halt, idle off, watchdog or detector on: slow clock runs, clear wdt.
// RULE5: halt, idle on, keep-clock off: stop CPU and fast oscillator.
// RULE6: halt, idle on, keep-clock on: stop only the CPU.
// RULE7: detector enabled in any low power mode forces slow clock on.
// RULE8: any halt entry sets power down flag, clears timeout flag.
// RULE9: divider codes 0,1 pick slow clock; 2..7 pick fast/64 to fast/2.
// RULE10: high clock select picks undivided fast clock.
// RULE11: running on slow clock stops fast oscillator and its timer ticks.
// RULE12: read-only slow ready flag rises one to two ticks after start.
// RULE13: read-only fast ready flag low when stopped, rises after 15-16.
// RULE14: software enters slow mode via codes 0 or 1, checks slow ready.
// RULE15: software returns to fast clock and checks fast ready first.
// RULE16: clock mode only by register writes; low power only by halt.
// RULE17: unimplemented register bits read as zero.
// RULE18: clock source switches glitch-free at period boundaries.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module pmc_power_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [pmc_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [pmc_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core and system events
  input wire logic halt_exec,
  input wire logic wake_req,
  input wire logic clear_wdt_instr,
  input wire logic wdt_timeout,
  input wire logic wdt_always_enabled,
  input wire logic wdt_enabled,
  input wire logic low_voltage_detect_enable,
  // slow rc oscillator output
  input wire logic slow_osc_pin,
  // clock controls
  output logic cpu_run,
  output logic sysclk_tick,
  output logic fast_osc_run,
  output logic slow_clk_run,
  output logic fast_div16_tick,
  output logic fast_div64_tick,
  // watchdog and detector controls
  output logic wdt_clear,
  output logic wdt_hold,
  output logic lvd_keep_on,
  // status flags
  output logic power_down_flag,
  output logic watchdog_timeout_flag
);
  import pmc_pkg::*;

  // 0 = mode register, 1 = control register, 2 = unmapped
  function automatic logic [1:0] pmc_decode(input logic [AXI_AW-1:0] a);
    if (a == MODE_OFFSET)
      return 2'h0;
    else if (a == CTRL_OFFSET)
      return 2'h1;
    else
      return 2'h2;
  endfunction : pmc_decode

  pmc_clk_if clk_if ();

  pmc_state_t st_reg;
  pmc_state_t st_next;
  logic [2:0] div_sel_reg;
  logic idle_on_halt_select_reg;
  logic high_clock_select_reg;
  logic keep_sysclk_in_idle_reg;
  logic low_voltage_reset_flag_reg;
  logic lrf_reg;
  logic wrf_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic slow_osc_ready_flag;
  logic fast_osc_ready_flag;

  // slow oscillator synchroniser and edge pick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= slow_osc_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  wire slow_tick = slow_clk_run && s2_reg && !s3_reg;

  // mode decisions
  wire wdt_on = wdt_always_enabled || wdt_enabled;
  wire deep_ok = !wdt_always_enabled && !wdt_on &&
                 !low_voltage_detect_enable; // RULE1 RULE3
  wire halt_enter = (st_reg == PM_RUN) && halt_exec; // RULE16
  wire [2:0] want_code = pmc_div_code(high_clock_select_reg,
                                      div_sel_reg); // RULE9 RULE10
  wire clk_alive = (st_next == PM_RUN) || (st_next == PM_CLOCKED_IDLE_MODE); // RULE6
  wire fast_need = clk_alive && ((want_code != SEL_SLOW) ||
                   (clk_if.cur_code != SEL_SLOW)); // RULE11
  wire slow_need = (st_next != PM_DEEP) ||
                   low_voltage_detect_enable; // RULE2 RULE7

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      PM_RUN:
      begin
        if (halt_exec && idle_on_halt_select_reg)
          st_next = keep_sysclk_in_idle_reg ? PM_CLOCKED_IDLE_MODE : PM_SLOW_IDLE_MODE; // RULE5
        else if (halt_exec)
          st_next = deep_ok ? PM_DEEP : PM_LIGHT; // RULE2 RULE4
      end
      default:
      begin
        if (wake_req)
          st_next = PM_RUN;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= PM_RUN;
      cpu_run <= 1'b0;
      fast_osc_run <= 1'b0;
      slow_clk_run <= 1'b0;
      wdt_clear <= 1'b0;
      wdt_hold <= 1'b0;
      lvd_keep_on <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cpu_run <= (st_next == PM_RUN);
      fast_osc_run <= fast_need; // RULE11
      slow_clk_run <= slow_need; // RULE7
      wdt_clear <= halt_enter; // RULE2 RULE4
      wdt_hold <= (st_next == PM_DEEP); // RULE2
      lvd_keep_on <= low_voltage_detect_enable; // RULE7
    end
  end

  // power down flag set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      power_down_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end
    else
    begin
      power_down_flag <= halt_enter ||
                         (power_down_flag && !clear_wdt_instr); // RULE8
      watchdog_timeout_flag <= wdt_timeout ||
                               (watchdog_timeout_flag && !halt_enter); // RULE8
    end
  end

  assign clk_if.want_code = want_code;
  assign clk_if.sys_run = (st_reg == PM_RUN) || (st_reg == PM_CLOCKED_IDLE_MODE);
  assign clk_if.fast_run = fast_osc_run;
  assign clk_if.slow_tick = slow_tick;
  assign sysclk_tick = clk_if.sys_tick;
  assign fast_div16_tick = clk_if.div16_tick;
  assign fast_div64_tick = clk_if.div64_tick;

  pmc_clk_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_if(clk_if)
  );

  pmc_ready_timer #(.N(SLOW_READY_TICKS)) u_slow_rdy (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(slow_clk_run),
    .tick(slow_tick),
    .ready(slow_osc_ready_flag)
  ); // RULE12

  pmc_ready_timer #(.N(FAST_READY_CYC)) u_fast_rdy (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(fast_osc_run),
    .tick(1'b1),
    .ready(fast_osc_ready_flag)
  ); // RULE13

  // register bus
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire ar_hs = arvalid && arready;
  wire do_write = !awready && !wready && !bvalid;
  wire [1:0] wsel = pmc_decode(awaddr_reg);
  wire [1:0] rsel = pmc_decode(araddr);
  wire [7:0] mode_rd = {div_sel_reg, 1'b0, slow_osc_ready_flag,
                        fast_osc_ready_flag, idle_on_halt_select_reg,
                        high_clock_select_reg}; // RULE17
  wire [7:0] ctrl_rd = {keep_sysclk_in_idle_reg, 4'h0, low_voltage_reset_flag_reg, lrf_reg,
                        wrf_reg}; // RULE17
  wire [7:0] rd_byte = (rsel == 2'h0) ? mode_rd :
                       (rsel == 2'h1) ? ctrl_rd : 8'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      awaddr_reg <= 4'h0;
      wbyte_reg <= 8'h0;
      wlane_reg <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        awready <= 1'b0;
        awaddr_reg <= awaddr;
      end
      if (w_hs)
      begin
        wready <= 1'b0;
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= (wsel == 2'h2) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // register store; clock fields change only by these writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_sel_reg <= DIV_RST;
      idle_on_halt_select_reg <= IDLE_SEL_RST;
      high_clock_select_reg <= HIGH_SEL_RST;
      keep_sysclk_in_idle_reg <= KEEP_RST;
      low_voltage_reset_flag_reg <= 1'b0;
      lrf_reg <= 1'b0;
      wrf_reg <= 1'b0;
    end
    else if (do_write && wlane_reg && (wsel == 2'h0))
    begin
      div_sel_reg <= wbyte_reg[DIV_LSB+:3]; // RULE16
      idle_on_halt_select_reg <= wbyte_reg[IDLE_SEL_BIT];
      high_clock_select_reg <= wbyte_reg[HIGH_SEL_BIT]; // RULE16
    end
    else if (do_write && wlane_reg && (wsel == 2'h1))
    begin
      keep_sysclk_in_idle_reg <= wbyte_reg[KEEP_BIT];
      low_voltage_reset_flag_reg <= wbyte_reg[LOW_VOLTAGE_RESET_FLAG_BIT];
      lrf_reg <= wbyte_reg[LRF_BIT];
      wrf_reg <= wbyte_reg[WRF_BIT];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h0, rd_byte};
      rresp <= (rsel == 2'h2) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // checks
  AST_NO_DEEP_ALWAYS: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_enter && wdt_always_enabled |=> st_reg != PM_DEEP) // RULE1
    else $error("deep sleep with always-on watchdog");
  AST_DEEP_ENTRY: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_enter && !idle_on_halt_select_reg && deep_ok |=>
    !cpu_run && !slow_clk_run && wdt_hold && wdt_clear) // RULE2
    else $error("deep sleep entry wrong");
  AST_NO_DEEP_LVD: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_enter && low_voltage_detect_enable |=> !wdt_hold) // RULE3
    else $error("deep sleep with detector enabled");
  AST_LIGHT_ENTRY: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_enter && !idle_on_halt_select_reg && wdt_on |=>
    slow_clk_run && wdt_clear && !wdt_hold && !cpu_run) // RULE4
    else $error("light sleep entry wrong");
  AST_SLOW_IDLE_MODE_ENTRY: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_enter && idle_on_halt_select_reg && !keep_sysclk_in_idle_reg |=>
    !fast_osc_run && slow_clk_run && !cpu_run ##1 !fast_osc_ready_flag)
    // RULE5
    else $error("slow idle entry wrong");
  AST_CLOCKED_IDLE_MODE_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_enter && idle_on_halt_select_reg && keep_sysclk_in_idle_reg |=>
    !cpu_run && slow_clk_run && (fast_osc_run == $past(fast_osc_run)))
    // RULE6
    else $error("clocked idle lost its clock");
  AST_LVD_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_next != PM_RUN) && low_voltage_detect_enable |=>
    slow_clk_run && lvd_keep_on) // RULE7
    else $error("detector did not force slow clock");
  AST_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_enter && !wdt_timeout |=> power_down_flag &&
    !watchdog_timeout_flag) // RULE8
    else $error("halt flags wrong");
  AST_SLOW_STOPS_FAST: assert property (@(posedge aclk) disable iff (!aresetn)
    (want_code == SEL_SLOW) && (clk_if.cur_code == SEL_SLOW) |=>
    !fast_osc_run ##1 !fast_div16_tick && !fast_div64_tick) // RULE11
    else $error("fast oscillator kept on slow clock");
  AST_FAST_READY: assert property (@(posedge aclk) disable iff (!aresetn)
    !fast_osc_ready_flag ##1 fast_osc_ready_flag |->
    $past(fast_osc_run, 15)) // RULE13
    else $error("fast ready too early");
  AST_CPU_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_run ##1 !cpu_run |-> $past(halt_exec)) // RULE16
    else $error("cpu stopped without halt");
  AST_RO_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> (rdata[31:8] == 24'h0) && !rdata[4]) // RULE17
    else $error("unimplemented bits read nonzero");
  COV_DEEP: cover property (@(posedge aclk) disable iff (!aresetn)
    halt_enter ##1 wdt_hold);
  COV_CLOCKED_IDLE_MODE: cover property (@(posedge aclk) disable iff (!aresetn)
    st_reg == PM_CLOCKED_IDLE_MODE && sysclk_tick);
  COV_SLOW_SWITCH: cover property (@(posedge aclk) disable iff (!aresetn)
    fast_osc_run ##1 !fast_osc_run && cpu_run);
  COV_WAKE: cover property (@(posedge aclk) disable iff (!aresetn)
    !cpu_run ##1 cpu_run);
endmodule : pmc_power_ctrl

/* tb_power_mode_clock_control.sv */
// Purpose: self-checking bench for the power mode clock controller
// Assumes: slow oscillator modelled as a 24-cycle square wave on aclk
// Notes: registers reached through a small AXI4-Lite master
`timescale 1ns/1ps
module tb_power_mode_clock_control;
  import pmc_pkg::*;
  logic aclk;
  logic aresetn;
  logic [AXI_AW-1:0] awaddr;
  logic [AXI_AW-1:0] araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  // {timeout, clear wdt, wake, halt}
  logic [3:0] ev;
  // {detector, wdt enabled, wdt always on}
  logic [2:0] cfg;
  logic slow_osc_pin;
  logic cpu_run, sysclk_tick, fast_osc_run, slow_clk_run;
  logic fast_div16_tick, fast_div64_tick, wdt_clear, wdt_hold;
  logic lvd_keep_on, power_down_flag, watchdog_timeout_flag;
  int n_fail;
  int n_compared;
  logic [7:0] slow_cnt;
  logic [1:0] rsp;
  logic [31:0] rd;
  wire [2:0] ticks = {fast_div64_tick, fast_div16_tick, sysclk_tick};

  pmc_power_ctrl u_pmc_power_ctrl (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .halt_exec(ev[0]), .wake_req(ev[1]), .clear_wdt_instr(ev[2]),
    .wdt_timeout(ev[3]), .wdt_always_enabled(cfg[0]),
    .wdt_enabled(cfg[1]), .low_voltage_detect_enable(cfg[2]),
    .slow_osc_pin(slow_osc_pin), .cpu_run(cpu_run),
    .sysclk_tick(sysclk_tick), .fast_osc_run(fast_osc_run),
    .slow_clk_run(slow_clk_run), .fast_div16_tick(fast_div16_tick),
    .fast_div64_tick(fast_div64_tick), .wdt_clear(wdt_clear),
    .wdt_hold(wdt_hold), .lvd_keep_on(lvd_keep_on),
    .power_down_flag(power_down_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag)
  );

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // slow oscillator: rising edge every 24 cycles
  always @(posedge aclk)
  begin
    slow_cnt <= (slow_cnt == 8'd11) ? 8'd0 : slow_cnt + 8'd1;
    if (slow_cnt == 8'd11)
      slow_osc_pin <= ~slow_osc_pin;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (bvalid !== 1'b1)
      n_fail++;
    bready <= 1'b0;
    check(bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (rvalid !== 1'b1)
      n_fail++;
    rready <= 1'b0;
    d = rdata;
    rsp = rresp;
  endtask : axi_rd

  task automatic pulse(input int k);
    @(posedge aclk);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
  endtask : pulse

  // cycles to the next tick of the chosen line, 200 when none comes
  task automatic tick_gap(input int idx, output int c);
    c = 0;
    do
    begin
      @(posedge aclk);
      c++;
    end while (ticks[idx] !== 1'b1 && c < 200);
  endtask : tick_gap

  task automatic meas(input int idx, input int exp);
    int c;
    repeat (3) tick_gap(idx, c);
    tick_gap(idx, c);
    check(c, exp);
  endtask : meas

  task automatic t_reset;
    axi_rd(MODE_OFFSET, rd);
    check(rd, 32'hc2);
    axi_rd(CTRL_OFFSET, rd);
    check(rd, 32'h00);
    repeat (80) @(posedge aclk);
    axi_rd(MODE_OFFSET, rd);
    check(rd, 32'hce);
    axi_rd(4'h8, rd);
    check({rsp, rd[29:0]}, {RESP_SLVERR, 30'h0});
    axi_wr(4'h8, 8'hff, RESP_SLVERR);
    axi_wr(MODE_OFFSET, 8'hff, RESP_OKAY);
    axi_rd(MODE_OFFSET, rd);
    check(rd, 32'hef);
    axi_wr(CTRL_OFFSET, 8'hff, RESP_OKAY);
    axi_rd(CTRL_OFFSET, rd);
    check(rd, 32'h87);
    check(cpu_run, 1'b1);
  endtask : t_reset

  task automatic t_clock;
    int k;
    int c;
    for (k = 7; k >= 0; k--)
    begin
      axi_wr(MODE_OFFSET, {k[2:0], 5'h00}, RESP_OKAY);
      meas(0, (k < 2) ? 24 : (1 << (8 - k)));
      check(cpu_run, 1'b1);
    end
    repeat (4) @(posedge aclk);
    check(fast_osc_run, 1'b0);
    tick_gap(1, c);
    check(c, 200);
    axi_rd(MODE_OFFSET, rd);
    check(rd[3:2], 2'b10);
    axi_wr(MODE_OFFSET, 8'h01, RESP_OKAY);
    axi_rd(MODE_OFFSET, rd);
    check(rd[3:2], 2'b10);
    repeat (24) @(posedge aclk);
    axi_rd(MODE_OFFSET, rd);
    check(rd[3:2], 2'b11);
    meas(0, 1);
    meas(1, 16);
    meas(2, 64);
  endtask : t_clock

  // e = expected {slow clock run, fast osc run, wdt hold}
  task automatic t_halt(input logic idle, input logic keep,
                        input logic [2:0] c, input logic [2:0] e);
    int n;
    axi_wr(MODE_OFFSET, {6'h30, idle, 1'b1}, RESP_OKAY);
    axi_wr(CTRL_OFFSET, {keep, 7'h00}, RESP_OKAY);
    cfg <= c;
    pulse(3);
    @(posedge aclk);
    check(watchdog_timeout_flag, 1'b1);
    pulse(0);
    n = 0;
    repeat (4)
    begin
      @(posedge aclk);
      n += int'(wdt_clear);
    end
    check(n, 1);
    check({cpu_run, slow_clk_run, fast_osc_run, wdt_hold}, {1'b0, e});
    check(lvd_keep_on, c[2]);
    check({power_down_flag, watchdog_timeout_flag}, 2'b10);
    if (idle && keep)
      meas(0, 1);
    if (idle && !keep)
      meas(0, 200);
    pulse(1);
    repeat (3) @(posedge aclk);
    check(cpu_run, 1'b1);
    pulse(2);
    repeat (2) @(posedge aclk);
    check(power_down_flag, 1'b0);
    cfg <= 3'h0;
  endtask : t_halt

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_sim;
  end

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'h0;
    ev = 4'h0;
    cfg = 3'h0;
    slow_osc_pin = 1'b0;
    slow_cnt = 8'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_clock;
    t_halt(1'b0, 1'b0, 3'b000, 3'b001);
    t_halt(1'b0, 1'b0, 3'b001, 3'b100);
    t_halt(1'b0, 1'b0, 3'b010, 3'b100);
    t_halt(1'b0, 1'b0, 3'b100, 3'b100);
    t_halt(1'b1, 1'b0, 3'b000, 3'b100);
    t_halt(1'b1, 1'b1, 3'b100, 3'b110);
    end_sim;
  end
endmodule : tb_power_mode_clock_control
